// ===== pkg/mpa_pkg.sv
package mpa_pkg;

  // ==========================================================================
  // widths and sizes
  localparam int ADDR_W    = 32;   // address width of every port
  localparam int DATA_W    = 256;  // one internal word per command
  localparam int NUM_RD    = 2;    // reader ports below the writer
  localparam int NUM_PORTS = NUM_RD + 1;
  localparam int PORT_W    = 2;    // port index width
  localparam int RD_CAP    = 128;  // default outstanding-read cap
  localparam int TAG_DEPTH = 256;  // tag entries, covers every read in flight
  localparam int TAG_AW    = 8;
  localparam logic [PORT_W-1:0] WR_PORT = 2'h0; // writer has top priority

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic              is_read;
    logic [ADDR_W-1:0] addr;
  } mpa_cmd_s;

  typedef struct packed {
    logic [PORT_W-1:0] port;
    logic              first;
    logic              last;
  } mpa_tag_s;

  typedef struct packed {
    logic [ADDR_W-1:0] first;
    logic [ADDR_W-1:0] last;
    logic [ADDR_W-1:0] low;
    logic [ADDR_W-1:0] high;
  } mpa_rd_addr_s;

  // ==========================================================================
  // next address with wrap, shared by both port kinds
  function automatic logic [ADDR_W-1:0] mpa_next_addr(input logic [ADDR_W-1:0] ptr,
                                                      input logic [ADDR_W-1:0] wrap_at,
                                                      input logic [ADDR_W-1:0] wrap_to);
    mpa_next_addr = (ptr == wrap_at) ? wrap_to : ptr + 32'h0000_0001;
  endfunction

endpackage

// ===== hdl/mpa_rd_port.sv
`timescale 1ns/100ps
`default_nettype none
module mpa_rd_port #(
  parameter int AFULL_DEPTH = mpa_pkg::RD_CAP
) (
  // clock and resets
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  input  wire logic                  port_reset,
  // client control
  input  wire logic                  strobe,
  input  wire logic                  abort,
  input  wire mpa_pkg::mpa_rd_addr_s addrs,
  input  wire logic                  afull,
  output logic                       sent,
  output logic                       done,
  // toward the command mux
  output logic                       req,
  output logic [mpa_pkg::ADDR_W-1:0] req_addr,
  output logic                       req_first,
  output logic                       req_last,
  input  wire logic                  grant,
  input  wire logic                  returned
);
  import mpa_pkg::*;

  localparam int CW = $clog2(AFULL_DEPTH + 1);
  localparam logic [CW-1:0] CAP = CW'(AFULL_DEPTH);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic              busy_r;
  logic              first_r;
  logic [ADDR_W-1:0] ptr_r;
  mpa_rd_addr_s      a_r;
  logic [CW-1:0]     outst_r;
  logic [CW-1:0]     outst_nxt;

  // ==========================================================================
  // request decode
  wire under_cap = outst_r < CAP;
  assign req       = busy_r && !afull && under_cap;
  assign req_addr  = ptr_r;
  assign req_first = first_r;
  assign req_last  = ptr_r == a_r.last;
  assign sent      = !busy_r;
  assign done      = !busy_r && (outst_r == '0);
  // in-flight count: a grant and a return in the same cycle cancel
  assign outst_nxt = (grant && !returned) ? outst_r + ONE :
                     (!grant && returned) ? outst_r - ONE : outst_r;

  // ==========================================================================
  // address walk over the requested area
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy_r  <= 1'b0;
      first_r <= 1'b0;
      ptr_r   <= '0;
      a_r     <= '0;
      outst_r <= '0;
    end else if (ce) begin
      if (port_reset) begin
        busy_r  <= 1'b0;
        first_r <= 1'b0;
        outst_r <= '0;
      end else begin
        outst_r <= outst_nxt;
        if (strobe && !busy_r) begin
          a_r     <= addrs;
          ptr_r   <= addrs.first;
          busy_r  <= 1'b1;
          first_r <= 1'b1;
        end else if (abort) begin
          busy_r <= 1'b0;                                // stop issuing, data still returns
        end else if (grant) begin
          ptr_r   <= mpa_next_addr(ptr_r, a_r.high, a_r.low);
          first_r <= 1'b0;
          if (req_last)
            busy_r <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== hdl/mpa_top.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - writer takes a 32-bit end address and wraps to start there
// - writer raises its done output when the write operation finishes
// - write data arrives as 256-bit words, one per accepted transfer
// - without write_last the writer wraps over its area forever
// - client empty stops the writer from pulling words
// - every word shown while read-acknowledge is high is captured and written
// - command mux grants by strict fixed priority, no fairness
// - selection follows highest not-empty port; commands taken next cycle
// - controller moves exactly one internal word per command
// - each port walks the whole requested address range by itself
// - every read command pushes the issuing port into the tag FIFO
// - returning data pops a tag; data goes to all ports, write strobe only to that port
// - each tag carries first-word and last-word flags
// - reader issues commands until the client raises almost-full
// - reader caps outstanding reads by parameter and pauses at the cap
// - first read word of an operation carries a one-word marker
// - write commands and data pass toward the controller through the command stage
module mpa_top #(
  parameter int AFULL_DEPTH = mpa_pkg::RD_CAP
) (
  // clock, reset, enable
  input  wire logic                                ref_clk,
  input  wire logic                                resetn,
  input  wire logic                                ce,
  // writer port
  input  wire logic                                write_reset,
  input  wire logic                                write_strobe,
  input  wire logic [mpa_pkg::ADDR_W-1:0]          write_first_addr,
  input  wire logic [mpa_pkg::ADDR_W-1:0]          write_last_addr,
  output logic                                     write_done,
  input  wire logic [mpa_pkg::DATA_W-1:0]          write_data,
  input  wire logic                                write_last,
  input  wire logic                                write_empty,
  output logic                                     write_read,
  // reader ports
  input  wire logic [mpa_pkg::NUM_RD-1:0]          read_reset,
  input  wire logic [mpa_pkg::NUM_RD-1:0]          read_strobe,
  input  wire logic [mpa_pkg::NUM_RD-1:0]          read_abort,
  input  wire mpa_pkg::mpa_rd_addr_s [mpa_pkg::NUM_RD-1:0] read_addrs,
  input  wire logic [mpa_pkg::NUM_RD-1:0]          read_afull,
  output logic [mpa_pkg::NUM_RD-1:0]               read_sent,
  output logic [mpa_pkg::NUM_RD-1:0]               read_done,
  output logic [mpa_pkg::DATA_W-1:0]               read_data,
  output logic [mpa_pkg::NUM_RD-1:0]               read_firstdata,
  output logic [mpa_pkg::NUM_RD-1:0]               read_lastdata,
  output logic [mpa_pkg::NUM_RD-1:0]               read_wr,
  // memory controller side
  output logic                                     mc_cmd_valid,
  input  wire logic                                mc_cmd_ready,
  output mpa_pkg::mpa_cmd_s                        mc_cmd,
  output logic [mpa_pkg::DATA_W-1:0]               mc_wdata,
  input  wire logic                                mc_rdata_valid,
  input  wire logic [mpa_pkg::DATA_W-1:0]          mc_rdata
);
  import mpa_pkg::*;

  localparam logic [TAG_AW:0] TAG_FULL = (TAG_AW+1)'(TAG_DEPTH);

  // ==========================================================================
  // writer state
  logic              w_busy_r;
  logic              w_done_r;
  logic [ADDR_W-1:0] w_ptr_r;
  logic [ADDR_W-1:0] w_start_r;
  logic [ADDR_W-1:0] w_end_r;

  // ==========================================================================
  // mux, command stage and tag FIFO state
  logic [PORT_W-1:0]    sel_r;
  logic [PORT_W-1:0]    sel_nxt;
  logic                 cmd_v_r;
  mpa_cmd_s             cmd_r;
  logic [DATA_W-1:0]    wdata_r;
  mpa_tag_s             tag_mem [TAG_DEPTH];
  logic [TAG_AW-1:0]    tag_wp_r;
  logic [TAG_AW-1:0]    tag_rp_r;
  logic [TAG_AW:0]      tag_cnt_r;
  logic [DATA_W-1:0]    rdata_r;
  logic [NUM_RD-1:0]    rwr_r;
  logic [NUM_RD-1:0]    rfirst_r;
  logic [NUM_RD-1:0]    rlast_r;

  // per-port request wires, index 0 is the writer
  logic [NUM_PORTS-1:0] req;
  logic [ADDR_W-1:0]    req_addr  [NUM_PORTS];
  logic [NUM_PORTS-1:0] req_first;
  logic [NUM_PORTS-1:0] req_last;
  logic [NUM_PORTS-1:0] grant;
  logic [NUM_RD-1:0]    returned;

  // ==========================================================================
  // command stage: taken when empty or when the controller takes the old one
  wire slot_free = !cmd_v_r || mc_cmd_ready;
  wire tag_full  = tag_cnt_r == TAG_FULL;               // reads wait, never overrun
  wire sel_rd    = sel_r != WR_PORT;
  wire take      = ce && slot_free && req[sel_r] && !(sel_rd && tag_full);
  wire take_rd   = take && sel_rd;
  wire tag_pop   = ce && mc_rdata_valid;
  mpa_tag_s tag_head;
  assign tag_head = tag_mem[tag_rp_r];

  // fixed priority: lowest index that asks wins
  always_comb begin
    sel_nxt = sel_r;                                    // hold while nobody asks
    for (int i = NUM_PORTS - 1; i >= 0; i--) begin
      if (req[i])
        sel_nxt = PORT_W'(i);
    end
  end

  // ==========================================================================
  // writer port, registered addresses, data straight into the command stage
  assign req[0]       = w_busy_r && !write_empty;
  assign req_addr[0]  = w_ptr_r;
  assign req_first[0] = 1'b0;
  assign req_last[0]  = 1'b0;
  assign grant[0]     = take && (sel_r == WR_PORT);
  assign write_read   = grant[0];
  assign write_done   = w_done_r;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      w_busy_r  <= 1'b0;
      w_done_r  <= 1'b0;
      w_ptr_r   <= '0;
      w_start_r <= '0;
      w_end_r   <= '0;
    end else if (ce) begin
      if (write_reset) begin
        w_busy_r <= 1'b0;
        w_done_r <= 1'b0;
      end else if (write_strobe) begin
        w_start_r <= write_first_addr;
        w_end_r   <= write_last_addr;
        w_ptr_r   <= write_first_addr;
        w_busy_r  <= 1'b1;
        w_done_r  <= 1'b0;
      end else if (grant[0]) begin
        w_ptr_r <= mpa_next_addr(w_ptr_r, w_end_r, w_start_r);
        if (write_last) begin
          w_busy_r <= 1'b0;
          w_done_r <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // reader ports
  for (genvar g = 0; g < NUM_RD; g++) begin : g_rd
    assign grant[g+1]    = take && (sel_r == PORT_W'(g + 1));
    assign returned[g]   = tag_pop && (tag_head.port == PORT_W'(g + 1));

    mpa_rd_port #(
      .AFULL_DEPTH (AFULL_DEPTH)
    ) u_rd (
      .ref_clk     (ref_clk),
      .resetn      (resetn),
      .ce          (ce),
      .port_reset  (read_reset[g]),
      .strobe      (read_strobe[g]),
      .abort       (read_abort[g]),
      .addrs       (read_addrs[g]),
      .afull       (read_afull[g]),
      .sent        (read_sent[g]),
      .done        (read_done[g]),
      .req         (req[g+1]),
      .req_addr    (req_addr[g+1]),
      .req_first   (req_first[g+1]),
      .req_last    (req_last[g+1]),
      .grant       (grant[g+1]),
      .returned    (returned[g])
    );
  end

  // ==========================================================================
  // selection register and command stage toward the controller
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sel_r   <= WR_PORT;
      cmd_v_r <= 1'b0;
      cmd_r   <= '0;
      wdata_r <= '0;
    end else if (ce) begin
      sel_r <= sel_nxt;
      if (take) begin
        cmd_v_r       <= 1'b1;
        cmd_r.is_read <= sel_rd;
        cmd_r.addr    <= req_addr[sel_r];
        wdata_r       <= write_data;
      end else if (mc_cmd_ready) begin
        cmd_v_r <= 1'b0;
      end
    end
  end

  assign mc_cmd_valid = cmd_v_r;
  assign mc_cmd       = cmd_r;
  assign mc_wdata     = wdata_r;

  // ==========================================================================
  // tag FIFO: pointers and count
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tag_wp_r  <= '0;
      tag_rp_r  <= '0;
      tag_cnt_r <= '0;
    end else if (ce) begin
      if (take_rd)
        tag_wp_r <= tag_wp_r + 1'b1;
      if (tag_pop)
        tag_rp_r <= tag_rp_r + 1'b1;
      if (take_rd && !tag_pop)
        tag_cnt_r <= tag_cnt_r + 1'b1;
      else if (!take_rd && tag_pop && tag_cnt_r != '0)
        tag_cnt_r <= tag_cnt_r - 1'b1;
    end
  end

  // tag storage has no reset so it maps onto memory
  always_ff @(posedge ref_clk) begin
    if (ce && take_rd)
      tag_mem[tag_wp_r] <= '{port: sel_r, first: req_first[sel_r], last: req_last[sel_r]};
  end

  // ==========================================================================
  // read return: data to all, valid and markers only to the tagged port
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r  <= '0;
      rwr_r    <= '0;
      rfirst_r <= '0;
      rlast_r  <= '0;
    end else if (ce) begin
      rdata_r  <= mc_rdata;
      rwr_r    <= returned;
      rfirst_r <= tag_head.first ? returned : '0;
      rlast_r  <= tag_head.last ? returned : '0;
    end
  end

  assign read_data      = rdata_r;
  assign read_wr        = rwr_r;
  assign read_firstdata = rfirst_r;
  assign read_lastdata  = rlast_r;

endmodule
`default_nettype wire

// ===== bench/mpa_mc_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// controller stand-in: one word per command, reads back in order
module mpa_mc_model #(
  parameter int LAT = 3
) (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       resetn,
  // bench knobs: stall the command side, hold back returns
  input  wire logic                       slow,
  input  wire logic                       hold,
  // command and data
  input  wire logic                       mc_cmd_valid,
  output logic                            mc_cmd_ready,
  input  wire mpa_pkg::mpa_cmd_s          mc_cmd,
  input  wire logic [mpa_pkg::DATA_W-1:0] mc_wdata,
  output logic                            mc_rdata_valid,
  output logic [mpa_pkg::DATA_W-1:0]      mc_rdata
);
  import mpa_pkg::*;
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] aq [$];
  int                tq [$];
  int                tk;
  // writes stored at once, reads queued with their arrival time
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tk = 0;
      aq.delete();
      tq.delete();
      mc_cmd_ready <= 1'b0;
      mc_rdata_valid <= 1'b0;
      mc_rdata <= '0;
    end else begin
      tk = tk + 1;
      if (mc_cmd_valid && mc_cmd_ready) begin
        if (mc_cmd.is_read) begin
          aq.push_back(mc_cmd.addr);
          tq.push_back(tk);
        end else begin
          mem[mc_cmd.addr] = mc_wdata;
        end
      end
      mc_cmd_ready <= !slow || tk[1];
      // exactly one word per read command, oldest first
      if (aq.size() > 0 && !hold && tk - tq[0] >= LAT) begin
        mc_rdata_valid <= 1'b1;
        mc_rdata <= mem.exists(aq[0]) ? mem[aq[0]] : {8{aq[0]}};
        void'(aq.pop_front());
        void'(tq.pop_front());
      end else begin
        mc_rdata_valid <= 1'b0;
        mc_rdata <= ~mc_rdata; // idle bus never repeats the last word
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/mpa_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// port checker
module mpa_monitor #(
  parameter int AFULL_DEPTH = mpa_pkg::RD_CAP
) (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       resetn,
  // writer side
  input  wire logic                       write_strobe,
  input  wire logic                       write_read,
  input  wire logic                       write_empty,
  input  wire logic                       write_last,
  input  wire logic                       write_done,
  input  wire logic [mpa_pkg::DATA_W-1:0] write_data,
  // reader side
  input  wire logic [mpa_pkg::NUM_RD-1:0] read_wr,
  input  wire logic [mpa_pkg::NUM_RD-1:0] read_firstdata,
  input  wire logic [mpa_pkg::NUM_RD-1:0] read_lastdata,
  input  wire logic [mpa_pkg::DATA_W-1:0] read_data,
  // controller side
  input  wire logic                       mc_cmd_valid,
  input  wire logic                       mc_cmd_ready,
  input  wire mpa_pkg::mpa_cmd_s          mc_cmd,
  input  wire logic [mpa_pkg::DATA_W-1:0] mc_wdata,
  input  wire logic                       mc_rdata_valid,
  input  wire logic [mpa_pkg::DATA_W-1:0] mc_rdata
);
  import mpa_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  int out_r;
  // reads taken by the controller and not yet answered
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      out_r <= 0;
    end else begin
      out_r <= out_r + int'(mc_cmd_valid && mc_cmd_ready && mc_cmd.is_read) - int'(mc_rdata_valid);
    end
  end
  // ==========================================================================
  // properties
  wr_capture_a: assert property (write_read |=> mc_cmd_valid && !mc_cmd.is_read
    && mc_wdata == $past(write_data)) else $error("taken word not sent on");
  empty_gate_a: assert property (write_empty |-> !write_read)
    else $error("word pulled from empty client");
  cmd_hold_a: assert property (mc_cmd_valid && !mc_cmd_ready |=> mc_cmd_valid
    && $stable(mc_cmd) && $stable(mc_wdata)) else $error("command dropped while stalled");
  ret_route_a: assert property (mc_rdata_valid |=> $onehot(read_wr)
    && read_data == $past(mc_rdata)) else $error("returned word not routed");
  no_stray_a: assert property (!mc_rdata_valid |=> read_wr == '0)
    else $error("reader output without a returned word");
  flag_gate_a: assert property (((read_firstdata | read_lastdata) & ~read_wr) == '0)
    else $error("flag outside a word");
  cap_bound_a: assert property (out_r <= NUM_RD * AFULL_DEPTH)
    else $error("too many reads in flight");
  done_rise_a: assert property (write_read && write_last |-> ##[1:2] write_done)
    else $error("done missing after final word");
  done_clear_a: assert property (write_strobe |=> !write_done)
    else $error("done stuck across restart");
  wr_cover: cover property (write_read && write_last);
  rd_cover: cover property (read_firstdata != '0);
  cap_cover: cover property (out_r == AFULL_DEPTH);
endmodule
bind mpa_top mpa_monitor #(.AFULL_DEPTH(AFULL_DEPTH)) i_mon (.ref_clk, .resetn, .write_strobe,
  .write_read, .write_empty, .write_last, .write_done, .write_data, .read_wr, .read_firstdata,
  .read_lastdata, .read_data, .mc_cmd_valid, .mc_cmd_ready, .mc_cmd, .mc_wdata, .mc_rdata_valid,
  .mc_rdata);
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// bench top
module tb;
  import mpa_pkg::*;
  localparam int CAP = 4;
  logic ref_clk = 1'b0, resetn = 1'b0, write_strobe = 1'b0, write_last = 1'b0;
  logic write_empty = 1'b1, slow = 1'b0, hold = 1'b0, write_reset = 1'b0;
  logic write_read, write_done, mc_cmd_valid, mc_cmd_ready, mc_rdata_valid;
  logic [ADDR_W-1:0] write_first_addr = '0, write_last_addr = '0, wexp, wfirst, wlast;
  logic [DATA_W-1:0] write_data = '0, mc_wdata, mc_rdata, read_data, wtop;
  logic [NUM_RD-1:0] read_strobe = '0, read_afull = '0, read_abort = '0, read_sent, read_done;
  logic [NUM_RD-1:0] read_firstdata, read_lastdata, read_wr;
  mpa_rd_addr_s [NUM_RD-1:0] read_addrs = '0;
  mpa_cmd_s mc_cmd;
  logic [DATA_W-1:0] wq [$];
  logic [DATA_W-1:0] sq [$];
  logic [DATA_W-1:0] emem [logic [ADDR_W-1:0]];
  int num_errors = 0, n_compared = 0, rdc = 0, gap = 0;
  always #5 ref_clk = ~ref_clk;
  mpa_top #(.AFULL_DEPTH(CAP)) i_dut (.ref_clk, .resetn, .ce(1'b1), .write_reset,
    .write_strobe, .write_first_addr, .write_last_addr, .write_done, .write_data, .write_last,
    .write_empty, .write_read, .read_reset(2'h0), .read_strobe, .read_abort, .read_addrs,
    .read_afull, .read_sent, .read_done, .read_data, .read_firstdata, .read_lastdata, .read_wr,
    .mc_cmd_valid, .mc_cmd_ready, .mc_cmd, .mc_wdata, .mc_rdata_valid, .mc_rdata);
  mpa_mc_model i_mc (.ref_clk, .resetn, .slow, .hold, .mc_cmd_valid, .mc_cmd_ready, .mc_cmd,
    .mc_wdata, .mc_rdata_valid, .mc_rdata);
  // client of the writer: gaps make the port wait for data
  always @(posedge ref_clk) if (write_read === 1'b1) sq.push_back(wq.pop_front());
  always @(negedge ref_clk) begin
    gap = gap + 1;
    write_empty = (wq.size() == 0) || (gap % 5 == 0);
    write_last = (wq.size() == 1);
    write_data = (wq.size() > 0) ? wq[0] : ~write_data;
  end
  // writes compared in order as the controller takes them, reads only counted
  always @(posedge ref_clk) begin
    if (mc_cmd_valid === 1'b1 && mc_cmd_ready === 1'b1) begin
      if (mc_cmd.is_read) rdc = rdc + 1;
      else begin
        wtop = sq.pop_front();
        chk(mc_cmd.addr, wexp);
        chk(mc_wdata, wtop);
        emem[wexp] = wtop;
        wexp = (wexp == wlast) ? wfirst : wexp + 32'h1;
      end
    end
  end
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic expire(input logic ok);
    if (ok !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: wait ran out, got %h expected %h", $time, ok, 1'b1);
      tally_and_finish();
    end
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_write(input logic [ADDR_W-1:0] f, l, nx, input int n);
    int i;
    wfirst = f;
    wlast = l;
    wexp = f;
    for (i = 0; i < n; i++) wq.push_back({8{f + 32'(i) + 32'ha5a5_0000}});
    write_first_addr = f;
    write_last_addr = l;
    write_strobe = 1'b1;
    @(negedge ref_clk);
    write_strobe = 1'b0;
    for (i = 0; i < 300 && write_done !== 1'b1; i++) @(negedge ref_clk);
    expire(write_done);
    repeat (8) @(negedge ref_clk);
    chk(wexp, nx);
    $display("test write %h done", f);
  endtask
  task automatic t_read(input int p, input logic [ADDR_W-1:0] f, l, input int n);
    logic [ADDR_W-1:0] a;
    int i, k;
    a = f;
    k = 0;
    read_addrs[p] = '{first: f, last: l, low: 32'h10, high: 32'h17};
    read_strobe[p] = 1'b1;
    @(negedge ref_clk);
    read_strobe[p] = 1'b0;
    for (i = 0; i < 400 && k < n; i++) begin
      @(negedge ref_clk);
      if (read_wr[p] === 1'b1) begin
        chk(read_data, emem[a]);
        chk(read_firstdata[p], k == 0);
        chk(read_lastdata[p], k == n - 1);
        a = (a == 32'h17) ? 32'h10 : a + 32'h1;
        k++;
      end
    end
    expire(k == n);
    chk(read_done[p], 1'b1);
    $display("test read port %0d done", p);
  endtask
  task automatic t_prio();
    int i;
    fork
      t_read(1, 32'h14, 32'h13, 8);
      begin
        repeat (3) @(negedge ref_clk);
        fork
          t_write(32'h20, 32'h21, 32'h20, 2);
          begin
            for (i = 0; i < 8 && !(mc_cmd_valid === 1'b1 && mc_cmd.is_read === 1'b0); i++)
              @(negedge ref_clk);
            chk(i < 5, 1'b1);
          end
        join
      end
    join
    $display("test priority done");
  endtask
  task automatic t_cap();
    int r0;
    r0 = rdc;
    hold = 1'b1;
    read_afull[1] = 1'b1; // port 1 client almost full, so only port 0 issues up to the cap
    fork
      t_read(0, 32'h12, 32'h11, 8);
      t_read(1, 32'h10, 32'h17, 8);
      begin
        repeat (30) @(negedge ref_clk);
        chk(rdc - r0, CAP);
        chk(read_sent[1], 1'b0);
        hold = 1'b0;
        read_afull[1] = 1'b0;
      end
    join
    $display("test cap done");
  endtask
  // abort stops issuing at once, but words already asked for must still drain
  task automatic t_abort();
    int i, r0;
    r0 = rdc;
    hold = 1'b1;
    read_addrs[0] = '{first: 32'h10, last: 32'h17, low: 32'h10, high: 32'h17};
    read_strobe[0] = 1'b1;
    @(negedge ref_clk);
    read_strobe[0] = 1'b0;
    repeat (12) @(negedge ref_clk);
    read_abort[0] = 1'b1;
    @(negedge ref_clk);
    read_abort[0] = 1'b0;
    chk(read_sent[0], 1'b1);
    chk(read_done[0], 1'b0);
    hold = 1'b0;
    for (i = 0; i < 50 && read_done[0] !== 1'b1; i++) @(negedge ref_clk);
    expire(read_done[0]);
    chk(rdc - r0, CAP);
    chk(write_done, 1'b1);
    write_reset = 1'b1;
    @(negedge ref_clk);
    write_reset = 1'b0;
    chk(write_done, 1'b0);
    $display("test abort done");
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    slow = 1'b1;
    t_write(32'h10, 32'h17, 32'h12, 10);
    slow = 1'b0;
    t_read(0, 32'h12, 32'h11, 8);
    t_prio();
    t_cap();
    t_abort();
    tally_and_finish();
  end
endmodule
`default_nettype wire
